// File: rtl/dfe_extract_unit.sv
// Execute-stage unit for the middle and upper doubleword field extracts.
`timescale 1ns/1ps

module dfe_extract_unit #(
  parameter int unsigned ARCH_RELEASE = dfe_pkg::DEF_RELEASE
) (
  clk,
  rst_n,
  req,
  resp
);
  input  wire logic            clk;
  input  wire logic            rst_n;
  input  wire dfe_pkg::dfe_req_t req;
  output dfe_pkg::dfe_resp_t   resp;

  // ==========================================================================
  // Field split of the instruction word
  // ==========================================================================
  wire logic [5:0]                    major_code;
  wire logic [5:0]                    func_code;
  wire logic [dfe_pkg::REG_IDX_W-1:0] target_register;
  wire logic [dfe_pkg::FIELD_W-1:0]   top_field;
  wire logic [dfe_pkg::FIELD_W-1:0]   start_field;

  assign major_code      = req.instr[dfe_pkg::MAJOR_HI:dfe_pkg::MAJOR_LO];
  assign func_code       = req.instr[dfe_pkg::FUNC_HI:dfe_pkg::FUNC_LO];
  assign target_register = req.instr[dfe_pkg::TGT_REG_HI:dfe_pkg::TGT_REG_LO];
  // The source index stays with the caller, which fetches the operand; this
  // unit never reads or writes a register of its own.
  assign top_field       = req.instr[dfe_pkg::TOP_HI:dfe_pkg::TOP_LO];
  assign start_field     = req.instr[dfe_pkg::START_HI:dfe_pkg::START_LO];

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire logic is_ext_major;
  wire logic middle_code;
  wire logic upper_code;
  wire logic is_middle;
  wire logic is_upper;
  wire logic is_mine;
  wire logic release_ok;

  assign is_ext_major = (major_code == dfe_pkg::EXT_MAJOR_OPCODE);
  assign middle_code  = (func_code == dfe_pkg::EXTRACT_MIDDLE_OP);
  assign upper_code   = (func_code == dfe_pkg::EXTRACT_UPPER_OP);
  // The plain extract shares the major code but belongs to another unit.
  assign is_middle    = req.valid & is_ext_major & middle_code;
  assign is_upper     = req.valid & is_ext_major & upper_code;
  assign is_mine      = is_middle | is_upper;
  // A compile-time constant: older cores keep the decode but refuse the work.
  assign release_ok   = (ARCH_RELEASE >= dfe_pkg::MIN_RELEASE);

  // ==========================================================================
  // Rebuilt field bounds
  // ==========================================================================
  function automatic logic [dfe_pkg::BOUND_W-1:0] widen(
    input logic [dfe_pkg::FIELD_W-1:0] f
  );
    widen = {{(dfe_pkg::BOUND_W - dfe_pkg::FIELD_W){1'b0}}, f};
  endfunction

  // A bound coded relative to the high word gets the word offset back.
  function automatic logic [dfe_pkg::BOUND_W-1:0] rebuild(
    input logic [dfe_pkg::FIELD_W-1:0] f,
    input logic                        high
  );
    rebuild = high ? widen(f) + dfe_pkg::WORD_OFFSET : widen(f);
  endfunction

  wire logic [dfe_pkg::BOUND_W-1:0] top_idx;
  wire logic [dfe_pkg::BOUND_W-1:0] start_pos;

  assign top_idx   = rebuild(top_field, is_middle);
  assign start_pos = rebuild(start_field, is_upper);

  // ==========================================================================
  // Range check
  // ==========================================================================
  wire logic [7:0] field_end;
  wire logic       over_end;

  assign field_end = {1'b0, start_pos} + {1'b0, top_idx} + 8'h01;
  // Out-of-range fields still produce a defined value: source bits past the
  // top read as zero. Software must not depend on it.
  assign over_end  = field_end > dfe_pkg::BOUND_LIMIT;

  // ==========================================================================
  // Field slice
  // ==========================================================================
  wire logic [dfe_pkg::DATA_W-1:0] field_value;

  dfe_field_slice #(
    .DATA_W (dfe_pkg::DATA_W)
  ) u_slice (
    .src   (req.src_value),
    .start (start_pos),
    .top   (top_idx),
    .field (field_value)
  );

  // ==========================================================================
  // Answer formation
  // ==========================================================================
  wire logic                          do_write;
  wire logic                          do_refuse;
  wire logic                          valid_d;
  wire logic                          wr_en_d;
  wire logic [dfe_pkg::REG_IDX_W-1:0] dest_idx_d;
  wire logic [dfe_pkg::DATA_W-1:0]    value_d;
  wire logic                          resv_instr_d;
  wire logic                          unpredictable_d;

  // Reserved-instruction is the only exception; no arithmetic trap exists.
  assign do_refuse = is_mine & ~release_ok;
  // A refused instruction must leave the target untouched.
  assign do_write  = is_mine & release_ok;

  assign valid_d         = is_mine;
  assign wr_en_d         = do_write;
  assign dest_idx_d      = is_mine ? target_register : '0;
  // A refused or foreign word loads zero, so no stale field ever shows.
  assign value_d         = do_write ? field_value : '0;
  assign resv_instr_d    = do_refuse;
  assign unpredictable_d = do_write & over_end;

  // ==========================================================================
  // Control flag registers
  // ==========================================================================
  // Each answer field has its own short register so the flags and the wide
  // value bank can be placed apart; every one reloads on every edge.
  logic                          valid_q;
  logic                          wr_en_q;
  logic [dfe_pkg::REG_IDX_W-1:0] dest_idx_q;
  logic                          resv_instr_q;
  logic                          unpredictable_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= dfe_pkg::RESP_RESET.valid;
    end else begin
      valid_q <= valid_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_en_q <= dfe_pkg::RESP_RESET.wr_en;
    end else begin
      wr_en_q <= wr_en_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dest_idx_q <= dfe_pkg::RESP_RESET.dest_idx;
    end else begin
      dest_idx_q <= dest_idx_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resv_instr_q <= dfe_pkg::RESP_RESET.resv_instr;
    end else begin
      resv_instr_q <= resv_instr_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unpredictable_q <= dfe_pkg::RESP_RESET.unpredictable;
    end else begin
      unpredictable_q <= unpredictable_d;
    end
  end

  // ==========================================================================
  // Result value register
  // ==========================================================================
  logic [dfe_pkg::DATA_W-1:0] value_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= dfe_pkg::RESP_RESET.value;
    end else begin
      value_q <= value_d;
    end
  end

  // ==========================================================================
  // Answer port
  // ==========================================================================
  // Every field leaves straight from its register, loaded on the same edge
  // that takes the request.
  assign resp = '{
    valid:         valid_q,
    wr_en:         wr_en_q,
    dest_idx:      dest_idx_q,
    value:         value_q,
    resv_instr:    resv_instr_q,
    unpredictable: unpredictable_q
  };

endmodule

// File: rtl/dfe_field_slice.sv
// Combinational zero-extending, right-justifying bit field slicer.
`timescale 1ns/1ps

module dfe_field_slice #(
  parameter int unsigned DATA_W = dfe_pkg::DATA_W
) (
  src,
  start,
  top,
  field
);
  input  wire logic [DATA_W-1:0]          src;
  input  wire logic [dfe_pkg::BOUND_W-1:0] start;
  input  wire logic [dfe_pkg::BOUND_W-1:0] top;
  output wire logic [DATA_W-1:0]          field;

  // ==========================================================================
  // Mask of top+1 low ones
  // ==========================================================================
  // Built by a right shift of all ones so a full-width field needs no special
  // case and no shift reaches the data width.
  function automatic logic [DATA_W-1:0] low_ones(input logic [dfe_pkg::BOUND_W-1:0] t);
    logic [DATA_W-1:0] ones;
    ones     = '1;
    low_ones = ones >> (DATA_W - 1 - int'(t));
  endfunction

  wire logic [DATA_W-1:0] shifted;
  wire logic [DATA_W-1:0] mask;

  // Bits beyond the top of the source shift in as zero.
  assign shifted = src >> start;
  assign mask    = low_ones(top);
  assign field   = shifted & mask;

endmodule

// File: rtl/dfe_pkg.sv
// Shared constants and carrier types for the doubleword field extract unit.
package dfe_pkg;

  // ==========================================================================
  // Instruction word layout
  // ==========================================================================
  localparam int unsigned INSTR_W     = 32;
  localparam int unsigned MAJOR_HI    = 31;
  localparam int unsigned MAJOR_LO    = 26;
  localparam int unsigned SRC_REG_HI  = 25;
  localparam int unsigned SRC_REG_LO  = 21;
  localparam int unsigned TGT_REG_HI  = 20;
  localparam int unsigned TGT_REG_LO  = 16;
  localparam int unsigned TOP_HI      = 15;
  localparam int unsigned TOP_LO      = 11;
  localparam int unsigned START_HI    = 10;
  localparam int unsigned START_LO    = 6;
  localparam int unsigned FUNC_HI     = 5;
  localparam int unsigned FUNC_LO     = 0;

  // ==========================================================================
  // Encodings
  // ==========================================================================
  localparam logic [5:0] EXT_MAJOR_OPCODE  = 6'h1f;
  localparam logic [5:0] EXTRACT_MIDDLE_OP = 6'h01;
  localparam logic [5:0] EXTRACT_UPPER_OP  = 6'h02;

  // ==========================================================================
  // Datapath sizes and field arithmetic
  // ==========================================================================
  localparam int unsigned DATA_W      = 64;
  localparam int unsigned REG_IDX_W   = 5;
  localparam int unsigned FIELD_W     = 5;
  localparam int unsigned BOUND_W     = 7;
  localparam logic [6:0]  WORD_OFFSET = 7'h20;
  localparam logic [7:0]  BOUND_LIMIT = 8'h40;
  localparam int unsigned MIN_RELEASE = 2;
  localparam int unsigned DEF_RELEASE = 2;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic                 valid;
    logic [INSTR_W-1:0]   instr;
    logic [DATA_W-1:0]    src_value;
  } dfe_req_t;

  typedef struct packed {
    logic                 valid;
    logic                 wr_en;
    logic [REG_IDX_W-1:0] dest_idx;
    logic [DATA_W-1:0]    value;
    logic                 resv_instr;
    logic                 unpredictable;
  } dfe_resp_t;

  localparam dfe_resp_t RESP_RESET = '0;

endpackage

// File: verification/dfe_checker.sv
// Port checks for the doubleword field extract unit.
`timescale 1ns/1ps
module dfe_checker #(
  parameter int unsigned ARCH_RELEASE = dfe_pkg::DEF_RELEASE
) (
  clk,
  rst_n,
  req,
  resp
);
  input wire logic               clk;
  input wire logic               rst_n;
  input wire dfe_pkg::dfe_req_t  req;
  input wire dfe_pkg::dfe_resp_t resp;
  wire [5:0] fn  = req.instr[5:0];
  wire       hit = req.valid && req.instr[31:26] == 6'h1f && (fn == 6'h01 || fn == 6'h02);
  wire       run = hit && ARCH_RELEASE >= 2;
  // An upper start lies in the high word, so bit 5 of the rebuilt start is the upper code.
  wire [5:0] st   = {fn == 6'h02, req.instr[10:6]};
  wire [6:0] top  = {1'b0, fn == 6'h01, req.instr[15:11]};
  wire       over = ({1'b0, st} + top) > 7'h3f;
  wire       sbit = req.src_value[st];
  // ==========================================================================
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  decode_valid_a: assert property (hit |=> resp.valid)
    else $error("extract not answered");
  ignore_other_a: assert property (!hit |=> !resp.valid && !resp.wr_en)
    else $error("foreign word answered");
  dest_index_a: assert property (hit |=> resp.dest_idx == $past(req.instr[20:16]))
    else $error("wrong target index");
  release_gate_a: assert property (hit |=> resp.wr_en == (ARCH_RELEASE >= 2)
    && resp.resv_instr == (ARCH_RELEASE < 2)) else $error("release gate wrong");
  exc_only_a: assert property (resp.resv_instr |-> resp.valid && !resp.wr_en)
    else $error("exception with write");
  overrun_flag_a: assert property (run |=> resp.unpredictable == $past(over))
    else $error("overrun flag wrong");
  field_base_a: assert property (run && !over |=> resp.value[0] == $past(sbit))
    else $error("field start wrong");
  zero_above_a: assert property (run |=> (resp.value >> ($past(top) + 1)) == 0)
    else $error("bits above field set");
  no_write_a: assert property (!resp.wr_en |-> resp.value == 0)
    else $error("value without write");
  cover property (run && fn == 6'h01);
  cover property (run && fn == 6'h02);
  cover property (run && over);
endmodule
bind dfe_extract_unit dfe_checker #(.ARCH_RELEASE(ARCH_RELEASE)) chk (
  .clk(clk), .rst_n(rst_n), .req(req), .resp(resp));

// File: verification/dfe_insn_source.sv
// Instruction producer model feeding extract requests to the unit.
`timescale 1ns/1ps
module dfe_insn_source (
  clk,
  req
);
  input  wire logic         clk;
  output dfe_pkg::dfe_req_t req;
  initial req = '0;
  // Idle cycles scramble the payload so a stale word is never mistaken for a live one.
  task automatic idle();
    @(negedge clk);
    req = '{valid: 1'b0, instr: ~req.instr, src_value: ~req.src_value};
  endtask
  task automatic send(input logic [31:0] instr, input logic [63:0] src);
    @(negedge clk);
    req = '{valid: 1'b1, instr: instr, src_value: src};
  endtask
  // Generic extract: the encoding follows where the field starts and how wide it is.
  task automatic extract(input int pos, input int size, input logic [63:0] src);
    logic [5:0] fn;
    logic [4:0] top;
    logic [4:0] st;
    fn = pos >= 32 ? 6'h02 : (size > 32 ? 6'h01 : 6'h03);
    top = 5'(fn == 6'h01 ? size - 33 : size - 1);
    st = 5'(fn == 6'h02 ? pos - 32 : pos);
    send({6'h1f, 5'($urandom), 5'($urandom), top, st, fn}, src);
  endtask
endmodule

// File: verification/doubleword_field_extract_tb.sv
// Self-checking bench for the doubleword field extract unit.
`timescale 1ns/1ps
module doubleword_field_extract_tb;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  int                 failures = 0;
  int                 comparisons = 0;
  dfe_pkg::dfe_req_t  req;
  dfe_pkg::dfe_resp_t resp, resp_old, exp_q, exp_old_q;
  always #5 clk = ~clk;
  dfe_insn_source src_m (.clk(clk), .req(req));
  dfe_extract_unit dut (.clk(clk), .rst_n(rst_n), .req(req), .resp(resp));
  dfe_extract_unit #(.ARCH_RELEASE(1)) dut_old (.clk(clk), .rst_n(rst_n), .req(req),
    .resp(resp_old));
  // ==========================================================================
  // Reference model
  function automatic dfe_pkg::dfe_resp_t model(dfe_pkg::dfe_req_t r, int rel);
    dfe_pkg::dfe_resp_t o;
    int fn;
    int top;
    int st;
    o = '0;
    fn = r.instr[5:0];
    top = r.instr[15:11] + (fn == 1 ? 32 : 0);
    st = r.instr[10:6] + (fn == 2 ? 32 : 0);
    if (r.valid && r.instr[31:26] == 6'h1f && (fn == 1 || fn == 2)) begin
      o.valid = 1'b1;
      o.dest_idx = r.instr[20:16];
      o.resv_instr = rel < 2;
      o.wr_en = rel >= 2;
      o.unpredictable = o.wr_en && st + top + 1 > 64;
      for (int i = 0; i <= top && st + i < 64; i++) begin
        o.value[i] = o.wr_en & r.src_value[st + i];
      end
    end
    return o;
  endfunction
  always @(posedge clk or negedge rst_n) begin
    exp_q <= rst_n ? model(req, 2) : '0;
    exp_old_q <= rst_n ? model(req, 1) : '0;
  end
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  always @(negedge clk) begin
    check("valid", 64'(resp.valid), 64'(exp_q.valid));
    check("write", 64'(resp.wr_en), 64'(exp_q.wr_en));
    check("dest", 64'(resp.dest_idx), 64'(exp_q.dest_idx));
    check("reserved", 64'(resp.resv_instr), 64'(exp_q.resv_instr));
    check("overrun", 64'(resp.unpredictable), 64'(exp_q.unpredictable));
    if (!exp_q.unpredictable) check("value", resp.value, exp_q.value);
    check("old reserved", 64'(resp_old.resv_instr), 64'(exp_old_q.resv_instr));
    check("old value", resp_old.value, exp_old_q.value);
  end
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    failures++;
    tally_and_finish();
  end
  initial begin
    int pos;
    void'($urandom(32'h498e));
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    src_m.extract(0, 64, 64'h8000_0000_0000_0001);
    src_m.extract(31, 33, ~64'h0);
    src_m.extract(63, 1, 64'h8000_0000_0000_0000);
    src_m.extract(32, 32, 64'hfedc_ba98_7654_3210);
    src_m.extract(5, 10, ~64'h0);
    src_m.send({6'h1f, 10'h0, 5'h1f, 5'h1f, 6'h01}, ~64'h0);
    src_m.send({6'h1f, 10'h0, 5'h1f, 5'h1f, 6'h02}, ~64'h0);
    src_m.send({6'h1e, 10'h0, 10'h0, 6'h01}, ~64'h0);
    src_m.idle();
    repeat (400) begin
      pos = $urandom % 64;
      src_m.extract(pos, 1 + $urandom % (64 - pos), {$urandom, $urandom});
      if ($urandom % 4 == 0) src_m.idle();
    end
    repeat (2) src_m.idle();
    tally_and_finish();
  end
endmodule
